// ===== hw/ext_exec_regs.svh
// Constants for the extended-instruction execution tail.
// Assumes inclusion by bare name from the package.
`ifndef EXT_EXEC_REGS_SVH
`define EXT_EXEC_REGS_SVH
`define EXEC_ACC_RESET 8'h00
`define EXEC_PTR_LO_RESET 8'h00
`define EXEC_PTR_HI_RESET 8'h00
`define EXEC_TAB_HI_RESET 8'h00
`define EXEC_FLAGS_RESET 6'h00
`define EXEC_LAST_PAGE_HI 8'hFF
`define EXEC_SKIP_CYCLES 2'h2
`define FLAG_C 0
`define FLAG_HALF 1
`define FLAG_Z 2
`define FLAG_RANGE 3
`define FLAG_SCMP 4
`define FLAG_CHAIN 5
`endif

// ===== hw/ext_exec_pkg.sv
// Types for the extended-instruction execution tail.
// Assumes the constants header is on the include path.
package ext_exec_pkg;
`include "ext_exec_regs.svh"
   typedef enum logic [10:0] {
      OP_SUBM = 11'h001, OP_SWAP = 11'h002, OP_SWAPA = 11'h004, OP_SZ = 11'h008,
      OP_SZA = 11'h010, OP_SZBIT = 11'h020, OP_TABRD = 11'h040, OP_TABRDL = 11'h080,
      OP_ITABRD = 11'h100, OP_ITABRDL = 11'h200, OP_XOR = 11'h400
   } op_type;
   typedef struct packed {
      logic valid;
      op_type op;
      logic xorm;
      logic [2:0] bit_sel;
      logic [7:0] mem;
   } instr_type;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mem_wr_type;
endpackage

// ===== hw/ext_alu.sv
// Arithmetic and logic unit of the execution tail.
// Assumes operands are stable in the issue cycle; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ext_alu (
   input wire logic [7:0] acc_i,
   input wire logic [7:0] mem_i,
   input wire logic [5:0] flags_i,
   input wire logic do_xor_i,
   output logic [7:0] result_o,
   output logic [5:0] flags_o
);
   import ext_exec_pkg::*;
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic rng_exc;
   logic [7:0] xres;
   // Subtract through a borrow bit; carry is inverted borrow
   assign diff = {1'b0, acc_i} - {1'b0, mem_i};
   assign low_diff = {1'b0, acc_i[3:0]} - {1'b0, mem_i[3:0]};
   assign rng_exc = (acc_i[7] ^ mem_i[7]) & (acc_i[7] ^ diff[7]);
   assign xres = acc_i ^ mem_i;
   assign result_o = do_xor_i ? xres : diff[7:0];
   // Compose flags; xor only touches zero
   always_comb begin
      flags_o = flags_i;
      if (do_xor_i) begin
         flags_o[`FLAG_Z] = (xres == 8'h00); // [RULE13] [RULE14]
      end else begin
         flags_o[`FLAG_C] = ~diff[8]; // [RULE2]
         flags_o[`FLAG_HALF] = ~low_diff[4];
         flags_o[`FLAG_Z] = (diff[7:0] == 8'h00);
         flags_o[`FLAG_RANGE] = rng_exc;
         flags_o[`FLAG_SCMP] = rng_exc ^ diff[7];
         flags_o[`FLAG_CHAIN] = (diff[7:0] == 8'h00) & flags_i[`FLAG_CHAIN];
      end
   end
endmodule // ext_alu
`default_nettype wire

// ===== hw/ext_exec_tail.sv
// Execution tail for the last group of extended instructions.
// Assumes decode presents one instruction per cycle with the operand already read.
// Function
// [RULE1] Subtract-to-memory writes accumulator minus data byte back to data byte.
// [RULE2] Subtract clears carry on negative, sets otherwise; updates other arithmetic flags.
// [RULE3] In-place nibble exchange swaps byte halves, writes back, flags unchanged.
// [RULE4] Nibble exchange to accumulator; data byte and flags unchanged.
// [RULE5] Byte zero test rewrites the byte and skips when zero; no flags.
// [RULE6] A taken skip inserts one dummy cycle; two cycles total.
// [RULE7] Copy-and-test loads accumulator and skips when value is zero.
// [RULE8] Bit zero test skips when the selected bit is zero.
// [RULE9] Paged table read uses both pointer bytes; low to memory, high to latch.
// [RULE10] Last-page table read uses the last page and the low pointer byte.
// [RULE11] Pre-increment paged read bumps the low pointer first, then reads.
// [RULE12] Pre-increment last-page read bumps the low pointer first, then reads.
// [RULE13] XOR-to-accumulator stores result in accumulator, zero flag only.
// [RULE14] XOR-to-memory stores result in data byte, zero flag only.
// [RULE15] Low pointer increment wraps at 256 with no carry into high byte.
`timescale 1ns/1ps
`default_nettype none
module ext_exec_tail (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire ext_exec_pkg::instr_type instr_i,
   output logic busy_o,
   output var ext_exec_pkg::mem_wr_type mem_wr_o,
   output logic [7:0] acc_o,
   output logic [5:0] flags_o,
   output logic skip_o,
   output logic [7:0] tptr_lo_o,
   output logic [7:0] tptr_hi_o,
   output logic [7:0] tab_hi_o,
   input wire logic tptr_lo_wr_i,
   input wire logic tptr_hi_wr_i,
   input wire logic [7:0] ptr_data_i,
   output logic prog_req_o,
   output logic [15:0] prog_addr_o,
   input wire logic [15:0] prog_data_i
);
   import ext_exec_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_TABLE = 3'h2,
      ST_DUMMY = 3'h4
   } state_type;

   state_type state_q, state_d;
   logic [7:0] acc_q, acc_d;
   logic [5:0] flags_q, flags_d;
   logic [7:0] tptr_lo_q, tptr_lo_d;
   logic [7:0] tptr_hi_q, tptr_hi_d;
   logic [7:0] tab_hi_q, tab_hi_d;
   mem_wr_type wr_q, wr_d;
   logic skip_q, skip_d;
   logic page_last_q, page_last_d;
   logic [7:0] alu_res;
   logic [5:0] alu_flags;

   ////////////////////////////////////////////////////////////////////////////
   // Table-read decode; the pre-increment and page tests feed more than one place
   function automatic logic op_is_preinc(input op_type op);
      return (op == OP_ITABRD) || (op == OP_ITABRDL);
   endfunction

   function automatic logic op_is_last(input op_type op);
      return (op == OP_TABRDL) || (op == OP_ITABRDL);
   endfunction

   function automatic logic op_is_table(input op_type op);
      return op_is_preinc(op) || op_is_last(op) || (op == OP_TABRD);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   wire logic go = instr_i.valid && (state_q == ST_IDLE);
   wire logic [7:0] m = instr_i.mem;
   wire logic [7:0] m_swapped = {m[3:0], m[7:4]};
   wire logic bit_is_zero = ~m[instr_i.bit_sel];
   wire logic is_table = op_is_table(instr_i.op);
   wire logic is_preinc = op_is_preinc(instr_i.op);
   wire logic is_last = op_is_last(instr_i.op);
   wire logic do_xor = (instr_i.op == OP_XOR);
   wire logic [7:0] tptr_lo_next = tptr_lo_q + 8'h01; // [RULE15]

   ext_alu u_alu (
      .acc_i(acc_q),
      .mem_i(m),
      .flags_i(flags_q),
      .do_xor_i(do_xor),
      .result_o(alu_res),
      .flags_o(alu_flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic; table reads take a second cycle for program memory
   always_comb begin
      state_d = state_q;
      acc_d = acc_q;
      flags_d = flags_q;
      tptr_lo_d = tptr_lo_wr_i ? ptr_data_i : tptr_lo_q;
      tptr_hi_d = tptr_hi_wr_i ? ptr_data_i : tptr_hi_q;
      tab_hi_d = tab_hi_q;
      wr_d = '0;
      skip_d = 1'b0;
      page_last_d = page_last_q;
      unique case (state_q)
         ST_IDLE: begin
            if (go) begin
               unique case (instr_i.op)
                  OP_SUBM: begin
                     wr_d = '{valid: 1'b1, data: alu_res}; // [RULE1]
                     flags_d = alu_flags; // [RULE2]
                  end
                  OP_SWAP: wr_d = '{valid: 1'b1, data: m_swapped}; // [RULE3]
                  OP_SWAPA: acc_d = m_swapped; // [RULE4]
                  OP_SZ: begin
                     wr_d = '{valid: 1'b1, data: m}; // [RULE5]
                     skip_d = (m == 8'h00);
                  end
                  OP_SZA: begin
                     acc_d = m; // [RULE7]
                     skip_d = (m == 8'h00);
                  end
                  OP_SZBIT: skip_d = bit_is_zero; // [RULE8]
                  OP_XOR: begin
                     flags_d = alu_flags;
                     if (instr_i.xorm) begin
                        wr_d = '{valid: 1'b1, data: alu_res}; // [RULE14]
                     end else begin
                        acc_d = alu_res; // [RULE13]
                     end
                  end
                  default: begin
                     // Table reads: pre-increment forms bump pointer now, address next cycle
                     if (is_table) begin
                        if (is_preinc) begin
                           tptr_lo_d = tptr_lo_next; // [RULE11] [RULE12]
                        end
                        page_last_d = is_last;
                        state_d = ST_TABLE;
                     end
                  end
               endcase
               if (skip_d) begin
                  state_d = ST_DUMMY; // [RULE6]
               end
            end
         end
         ST_TABLE: begin
            wr_d = '{valid: 1'b1, data: prog_data_i[7:0]}; // [RULE9] [RULE10]
            tab_hi_d = prog_data_i[15:8];
            state_d = ST_IDLE;
         end
         ST_DUMMY: begin
            skip_d = 1'b1; // Hold skip for the dummy fetch cycle
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state, skip strobe and page choice
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         skip_q <= 1'b0;
         page_last_q <= 1'b0;
      end else begin
         state_q <= state_d;
         skip_q <= skip_d;
         page_last_q <= page_last_d;
      end
   end

   // Accumulator and flags
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= `EXEC_ACC_RESET;
         flags_q <= `EXEC_FLAGS_RESET;
      end else begin
         acc_q <= acc_d;
         flags_q <= flags_d;
      end
   end

   // Table pointer bytes; a pre-increment outranks a write to the low byte
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tptr_lo_q <= `EXEC_PTR_LO_RESET;
         tptr_hi_q <= `EXEC_PTR_HI_RESET;
      end else begin
         tptr_lo_q <= tptr_lo_d;
         tptr_hi_q <= tptr_hi_d;
      end
   end

   // Table-high latch and the one-cycle data write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tab_hi_q <= `EXEC_TAB_HI_RESET;
         wr_q <= '0;
      end else begin
         tab_hi_q <= tab_hi_d;
         wr_q <= wr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; program address uses the already-incremented pointer
   assign prog_req_o = (state_q == ST_TABLE);
   assign prog_addr_o = page_last_q ? {`EXEC_LAST_PAGE_HI, tptr_lo_q} : {tptr_hi_q, tptr_lo_q}; // [RULE10] [RULE9]
   assign busy_o = (state_q != ST_IDLE); // Stalls decode during table and dummy cycles
   assign mem_wr_o = wr_q;
   assign acc_o = acc_q;
   assign flags_o = flags_q;
   assign skip_o = skip_q;
   assign tptr_lo_o = tptr_lo_q;
   assign tptr_hi_o = tptr_hi_q;
   assign tab_hi_o = tab_hi_q;
endmodule // ext_exec_tail
`default_nettype wire

// ===== sim/ext_exec_tail_props.sv
// Checker for the extended-instruction execution tail.
// Assumes it sees only the top module's ports, attached by bind.
`timescale 1ns/1ps
`default_nettype none
module ext_exec_tail_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire ext_exec_pkg::instr_type instr_i,
   input wire logic busy_o,
   input wire ext_exec_pkg::mem_wr_type mem_wr_o,
   input wire logic [7:0] acc_o,
   input wire logic [5:0] flags_o,
   input wire logic skip_o,
   input wire logic [7:0] tptr_lo_o,
   input wire logic [7:0] tptr_hi_o,
   input wire logic [7:0] tab_hi_o,
   input wire logic prog_req_o,
   input wire logic [15:0] prog_addr_o,
   input wire logic [15:0] prog_data_i
);
   import ext_exec_pkg::*;
   // Issue needs an idle tail; requests seen while busy are dropped
   wire logic go = instr_i.valid && !busy_o;
   wire logic [10:0] op = instr_i.op;
   wire logic [7:0] m = instr_i.mem;
   wire logic sel_bit = m[instr_i.bit_sel];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////
   a_sub_result: assert property (
      go && op == OP_SUBM |=> mem_wr_o.valid && mem_wr_o.data == $past(acc_o) - $past(m)
      && flags_o[0] == ($past(acc_o) >= $past(m))) else $error("subtract wrong");
   a_swap_inplace: assert property (
      go && op == OP_SWAP |=> mem_wr_o.valid && mem_wr_o.data == {$past(m[3:0]), $past(m[7:4])}
      && $stable(flags_o)) else $error("swap wrong");
   a_byte_skip: assert property (
      go && op == OP_SZ |=> mem_wr_o.data == $past(m) && skip_o == ($past(m) == 8'h00)
      && $stable(flags_o)) else $error("zero test wrong");
   a_skip_dummy: assert property (
      $rose(skip_o) |-> busy_o ##1 skip_o && !busy_o) else $error("dummy cycle wrong");
   a_bit_skip: assert property (
      go && op == OP_SZBIT |=> skip_o == !$past(sel_bit)) else $error("bit test wrong");
   a_paged_read: assert property (
      go && (op == OP_TABRD || op == OP_ITABRD) |=> prog_req_o
      && prog_addr_o == {$past(tptr_hi_o), $past(tptr_lo_o) + {7'h00, $past(op) == OP_ITABRD}}
      ##1 mem_wr_o.valid && {tab_hi_o, mem_wr_o.data} == $past(prog_data_i)) else $error("paged read wrong");
   a_last_page: assert property (
      go && (op == OP_TABRDL || op == OP_ITABRDL) |=> prog_req_o
      && prog_addr_o == {8'hFF, $past(tptr_lo_o) + {7'h00, $past(op) == OP_ITABRDL}}
      && tptr_lo_o == $past(tptr_lo_o) + {7'h00, $past(op) == OP_ITABRDL}) else $error("last page read wrong");
   a_xor_acc: assert property (
      go && op == OP_XOR && !instr_i.xorm |=> acc_o == $past(acc_o ^ m) && flags_o[2] == (acc_o == 8'h00)
      && (flags_o & 6'h3B) == $past(flags_o & 6'h3B)) else $error("xor wrong");
endmodule // ext_exec_tail_props
bind ext_exec_tail ext_exec_tail_props ext_exec_tail_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .instr_i(instr_i), .busy_o(busy_o), .mem_wr_o(mem_wr_o), .acc_o(acc_o), .flags_o(flags_o),
   .skip_o(skip_o), .tptr_lo_o(tptr_lo_o), .tptr_hi_o(tptr_hi_o), .tab_hi_o(tab_hi_o), .prog_req_o(prog_req_o),
   .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i));
`default_nettype wire

// ===== sim/prog_mem_model.sv
// Program memory model holding table data.
// Assumes a word is read in the same cycle as the request.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input wire logic prog_req_i,
   input wire logic [15:0] prog_addr_i,
   output logic [15:0] prog_data_o
);
   // High byte copies the low address byte, low byte inverts the high one, so a wrong page shows
   wire logic [15:0] word = {prog_addr_i[7:0], ~prog_addr_i[15:8]};
   // Off request the bus shows the inverse, never a held word
   assign prog_data_o = prog_req_i ? word : ~word;
endmodule // prog_mem_model
`default_nettype wire

// ===== sim/ext_exec_tail_tb.sv
// Testbench for the extended-instruction execution tail.
// Assumes the program memory model answers in the request cycle.
`timescale 1ns/1ps
`default_nettype none
module ext_exec_tail_tb;
   import ext_exec_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, tptr_lo_wr_i = 1'b0, tptr_hi_wr_i = 1'b0;
   logic busy_o, skip_o, prog_req_o, s1, b1, s2, b2;
   logic [7:0] ptr_data_i = 8'h00, acc_o, tptr_lo_o, tptr_hi_o, tab_hi_o;
   logic [5:0] flags_o, f0;
   logic [15:0] prog_addr_o, prog_data_i;
   instr_type instr_i = '0;
   mem_wr_type mem_wr_o, w1, w2;
   int error_cnt = 0, tests_run = 0;
   always #2.5 clk_i = ~clk_i;
   ext_exec_tail ext_exec_tail_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .busy_o(busy_o),
      .mem_wr_o(mem_wr_o), .acc_o(acc_o), .flags_o(flags_o), .skip_o(skip_o), .tptr_lo_o(tptr_lo_o),
      .tptr_hi_o(tptr_hi_o), .tab_hi_o(tab_hi_o), .tptr_lo_wr_i(tptr_lo_wr_i), .tptr_hi_wr_i(tptr_hi_wr_i),
      .ptr_data_i(ptr_data_i), .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i));
   prog_mem_model prog_mem_model_inst (.prog_req_i(prog_req_o), .prog_addr_i(prog_addr_o),
      .prog_data_o(prog_data_i));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One issue, then snapshots of the two cycles after it
   task automatic run(input op_type op, input logic [7:0] m, input logic x = 1'b0, input logic [2:0] b = 3'h0);
      @(negedge clk_i);
      f0 = flags_o;
      instr_i = '{1'b1, op, x, b, m};
      @(negedge clk_i);
      instr_i.valid = 1'b0;
      {w1, s1, b1} = {mem_wr_o, skip_o, busy_o};
      @(negedge clk_i);
      {w2, s2, b2} = {mem_wr_o, skip_o, busy_o};
      $display("test %s done", op.name());
   endtask
   // Pointer writes last one cycle; high selects the page byte
   task automatic wptr(input logic hi, input logic [7:0] d);
      @(negedge clk_i);
      {tptr_hi_wr_i, tptr_lo_wr_i, ptr_data_i} = {hi, !hi, d};
      @(negedge clk_i);
      {tptr_hi_wr_i, tptr_lo_wr_i} = 2'b00;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk({acc_o, tptr_lo_o}, 16'h0000);
      run(OP_SZA, 8'h35);
      chk({acc_o, 7'h00, s1, 2'b00, flags_o}, {8'h35, 8'h00, 2'b00, f0});
      run(OP_SUBM, 8'h50);
      chk({w1.data, 7'h00, flags_o[0]}, 16'hE500);
      run(OP_SUBM, 8'h10);
      chk({w1.data, 7'h00, flags_o[0]}, 16'h2501);
      run(OP_SWAP, 8'h3C);
      chk({w1.valid, w1.data, 1'b0, flags_o}, {9'h1C3, 1'b0, f0});
      run(OP_SWAPA, 8'hA7);
      chk({w1.valid, acc_o, 1'b0, flags_o}, {9'h07A, 1'b0, f0});
      run(OP_SZ, 8'h00);
      chk({w1.valid, w1.data, s1, b1, s2, b2}, {9'h100, 4'b1110});
      run(OP_SZ, 8'h01);
      chk({w1.data, s1, b1}, 10'h004);
      for (int i = 0; i < 8; i++) begin
         run(OP_SZBIT, 8'h01 << i, 1'b0, i[2:0]);
         chk({s1, flags_o}, {1'b0, f0});
         run(OP_SZBIT, 8'h01 << i, 1'b0, 3'(i + 1));
         chk({s1, b1}, 2'b11);
      end
      run(OP_XOR, 8'h7A);
      chk({acc_o, 2'b00, flags_o}, {10'h000, f0 | 6'h04});
      run(OP_XOR, 8'h55, 1'b1);
      chk({w1.data, acc_o, 2'b00, flags_o}, {16'h5500, 2'b00, f0 & 6'h3B});
      wptr(1'b1, 8'h12);
      wptr(1'b0, 8'h34);
      run(OP_TABRD, 8'h00);
      chk({w2.data, tab_hi_o}, 16'hED34);
      run(OP_TABRDL, 8'h00);
      chk({w2.data, tab_hi_o}, 16'h0034);
      run(OP_ITABRD, 8'h00);
      chk({w2.data, tab_hi_o}, 16'hED35);
      wptr(1'b0, 8'hFF);
      run(OP_ITABRDL, 8'h00);
      chk({w2.data, tab_hi_o, tptr_hi_o, tptr_lo_o}, 32'h00001200);
      tally_and_finish;
   end
   // Whole run is well under a microsecond; this cuts a hang short
   initial begin
      #20000;
      error_cnt++;
      tally_and_finish;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
endmodule // ext_exec_tail_tb
`default_nettype wire
